// ---- core/lbrk_pkg.sv ----
// Shared constants, types and register map of the break-capable serial port.
package lbrk_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_TXD = 5'h08;
    localparam logic [4:0] OFS_RXD = 5'h0c;
    localparam logic [4:0] OFS_BAUD = 5'h10;
    localparam logic [4:0] OFS_ISTAT = 5'h14;
    localparam logic [4:0] OFS_IMASK = 5'h18;

    // Status register bit positions.
    localparam int STAT_SHIFT_REGISTER_EMPTY = 0;
    localparam int STAT_TRANSMIT_BUFFER_EMPTY_FLAG = 1;
    localparam int STAT_RECEIVE_DATA_FLAG = 2;
    localparam int STAT_FRAMING_ERROR_FLAG = 3;

    // Interrupt status and mask bit positions.
    localparam int IRQ_W = 4;
    localparam int IRQ_RX = 0;
    localparam int IRQ_TXE = 1;
    localparam int IRQ_BRK = 2;
    localparam int IRQ_FRAMING_ERROR_FLAG = 3;

    // Reset values.
    localparam logic [15:0] BAUD_RESET = 16'h0004;
    localparam logic [IRQ_W-1:0] IMASK_RESET = 4'h0;

    // Oversampling and frame shape.
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] BREAK_BITS = 4'hc;

    // Control register; transmit_enable sits in bit 0, rxen in bit 4.
    typedef struct packed {
        logic rxen;
        logic abd;
        logic wake;
        logic send_break_request;
        logic transmit_enable;
    } lbrk_ctrl_type;

    // One received character with its framing result.
    typedef struct packed {
        logic framing_error_flag;
        logic [7:0] data;
    } lbrk_rxchar_type;

    // Transmitter and receiver sequencers.
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP}
        lbrk_tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP,
        RX_WAKE_LOW, RX_WAKE_HIGH} lbrk_rx_state_type;

endpackage

// ---- core/lbrk_serial.sv ----
// Serial port with LIN break transmit and break receive handling.
`timescale 1ns/1ps
module lbrk_serial (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial line
    input wire logic receive_line,
    output logic transmit_line,
    // Interrupt
    output logic irq
);

    // Bus handshake: one wait cycle, then the access commits.
    logic wait_q;
    logic [31:0] rdata_q;
    wire req = avs_read | avs_write;
    wire commit = req & ~wait_q;
    wire be0 = avs_byteenable[0];
    wire be1 = avs_byteenable[1];
    wire sel_ctrl = avs_address == lbrk_pkg::OFS_CTRL;
    wire sel_stat = avs_address == lbrk_pkg::OFS_STAT;
    wire sel_txd = avs_address == lbrk_pkg::OFS_TXD;
    wire sel_rxd = avs_address == lbrk_pkg::OFS_RXD;
    wire sel_baud = avs_address == lbrk_pkg::OFS_BAUD;
    wire sel_istat = avs_address == lbrk_pkg::OFS_ISTAT;
    wire sel_imask = avs_address == lbrk_pkg::OFS_IMASK;
    wire wr = commit & avs_write;
    wire rd = commit & avs_read;

    // Software-visible state.
    lbrk_pkg::lbrk_ctrl_type ctrl_q, ctrl_d;
    logic [15:0] baud_q;
    logic [lbrk_pkg::IRQ_W-1:0] istat_q, imask_q, ev;
    logic irq_q;
    lbrk_pkg::lbrk_rxchar_type rxc_q;
    logic receive_data_flag_q;

    // Transmit holding register and shifter.
    logic [7:0] hold_q;
    logic hold_full_q, hold_brk_q;
    lbrk_pkg::lbrk_tx_state_type tx_st_q;
    logic [7:0] tsh_q;
    logic tsh_brk_q;
    logic [3:0] tcnt_q, tbit_q;
    logic tx_line_q;

    // Receiver.
    logic rx_s1_q, rx_s2_q, rx_prev_q;
    lbrk_pkg::lbrk_rx_state_type rx_st_q;
    logic [3:0] rcnt_q, rbit_q;
    logic [7:0] rsh_q;

    // Baud divider producing the sixteen-times oversampling enable.
    // Comparing at or above the divisor means a divisor lowered below the
    // running count restarts at once instead of waiting for a wrap.
    logic [15:0] bcnt_q;
    wire tick = bcnt_q >= baud_q;

    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            bcnt_q <= 16'h0000;
        end else begin
            bcnt_q <= bcnt_q + 16'h0001;
        end
    end

    // Write strobes for the data and control paths.
    wire tx_idle = tx_st_q == lbrk_pkg::TX_IDLE;
    wire brk_busy = hold_brk_q | (~tx_idle & tsh_brk_q);
    // A full holding register refuses the write; software must wait.
    wire tx_wr = wr & sel_txd & be0 & ctrl_q.transmit_enable & ~hold_full_q;
    // Only one break may be outstanding, so a sync byte written while
    // the request bit is still set is sent as an ordinary character.
    wire tx_arm = ctrl_q.send_break_request & ctrl_q.transmit_enable & ~brk_busy;
    wire tx_load = tx_idle & hold_full_q;
    wire bit_end = tick & (tcnt_q == lbrk_pkg::OVS_LAST);
    wire [3:0] nbits = tsh_brk_q ? lbrk_pkg::BREAK_BITS
                                 : lbrk_pkg::DATA_BITS;
    wire tx_stop_end = (tx_st_q == lbrk_pkg::TX_STOP) & bit_end;
    wire brk_done = tx_stop_end & tsh_brk_q;
    // Shifter empty is the same signal for breaks and characters.
    wire shift_register_empty = tx_idle;

    // Receiver events.
    wire rx_fall = rx_prev_q & ~rx_s2_q;
    wire rx_rise = ~rx_prev_q & rx_s2_q;
    wire r_end = tick & (rcnt_q == lbrk_pkg::OVS_LAST);
    wire rx_done = (rx_st_q == lbrk_pkg::RX_STOP) & r_end;
    wire wake_done = (rx_st_q == lbrk_pkg::RX_WAKE_HIGH) & rx_rise;
    wire rx_ev = rx_done | wake_done;
    wire rx_framing_error_flag = ~rx_s2_q;

    // Control register next value: hardware clears first, a software
    // write in the same cycle overrides so a fresh arm is never lost.
    always_comb begin
        ctrl_d = ctrl_q;
        if (brk_done) begin
            ctrl_d.send_break_request = 1'b0;
        end
        if (wake_done) begin
            ctrl_d.wake = 1'b0;
        end
        if (wr && sel_ctrl && be0) begin
            ctrl_d = lbrk_pkg::lbrk_ctrl_type'(avs_writedata[4:0]);
        end
    end

    // Interrupt events.
    always_comb begin
        ev = '0;
        ev[lbrk_pkg::IRQ_RX] = rx_ev;
        ev[lbrk_pkg::IRQ_TXE] = tx_load;
        ev[lbrk_pkg::IRQ_BRK] = brk_done;
        ev[lbrk_pkg::IRQ_FRAMING_ERROR_FLAG] = rx_done & rx_framing_error_flag;
    end

    // Read data selection; unmapped offsets read as zero.
    logic [31:0] rword;
    always_comb begin
        rword = 32'h0000_0000;
        if (sel_ctrl) begin
            rword[4:0] = ctrl_q;
        end
        if (sel_stat) begin
            rword[lbrk_pkg::STAT_SHIFT_REGISTER_EMPTY] = shift_register_empty;
            rword[lbrk_pkg::STAT_TRANSMIT_BUFFER_EMPTY_FLAG] = ~hold_full_q;
            rword[lbrk_pkg::STAT_RECEIVE_DATA_FLAG] = receive_data_flag_q;
            rword[lbrk_pkg::STAT_FRAMING_ERROR_FLAG] = rxc_q.framing_error_flag;
        end
        if (sel_rxd) begin
            rword[7:0] = rxc_q.data;
        end
        if (sel_baud) begin
            rword[15:0] = baud_q;
        end
        if (sel_istat) begin
            rword[lbrk_pkg::IRQ_W-1:0] = istat_q;
        end
        if (sel_imask) begin
            rword[lbrk_pkg::IRQ_W-1:0] = imask_q;
        end
    end

    // Bus handshake and software registers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (avs_read && wait_q) begin
                rdata_q <= rword;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= '0;
            baud_q <= lbrk_pkg::BAUD_RESET;
            imask_q <= lbrk_pkg::IMASK_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr && sel_baud && be0) begin
                baud_q[7:0] <= avs_writedata[7:0];
            end
            if (wr && sel_baud && be1) begin
                baud_q[15:8] <= avs_writedata[15:8];
            end
            if (wr && sel_imask && be0) begin
                imask_q <= avs_writedata[lbrk_pkg::IRQ_W-1:0];
            end
        end
    end

    // Sticky status, cleared by a read; a new event wins over the clear.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            istat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            istat_q <= (istat_q & {lbrk_pkg::IRQ_W{~(rd & sel_istat)}}) | ev;
            irq_q <= |(istat_q & imask_q);
        end
    end

    // Received character and its data flag, cleared by reading it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxc_q <= '0;
            receive_data_flag_q <= 1'b0;
        end else begin
            if (rx_done) begin
                rxc_q <= {rx_framing_error_flag, rsh_q};
            end else if (wake_done) begin
                rxc_q <= '0;
            end
            receive_data_flag_q <= rx_ev | (receive_data_flag_q & ~(rd & sel_rxd));
        end
    end

    // Holding register: accepts the next byte as soon as the shifter has
    // taken the previous one, including while a break is on the line.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_q <= 8'h00;
            hold_full_q <= 1'b0;
            hold_brk_q <= 1'b0;
        end else if (tx_wr) begin
            hold_q <= avs_writedata[7:0];
            hold_full_q <= 1'b1;
            hold_brk_q <= tx_arm;
        end else if (tx_load) begin
            hold_full_q <= 1'b0;
            hold_brk_q <= 1'b0;
        end
    end

    // Transmit sequencer; a break shifts twelve zero bits in place of data.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_st_q <= lbrk_pkg::TX_IDLE;
            tsh_q <= 8'h00;
            tsh_brk_q <= 1'b0;
            tcnt_q <= 4'h0;
            tbit_q <= 4'h0;
        end else begin
            if (tick) begin
                tcnt_q <= tcnt_q + 4'h1;
            end
            unique case (tx_st_q)
                lbrk_pkg::TX_IDLE: begin
                    if (tx_load) begin
                        tsh_q <= hold_brk_q ? 8'h00 : hold_q;
                        tsh_brk_q <= hold_brk_q;
                        tcnt_q <= 4'h0;
                        tbit_q <= 4'h0;
                        tx_st_q <= lbrk_pkg::TX_START;
                    end
                end
                lbrk_pkg::TX_START: begin
                    if (bit_end) begin
                        tx_st_q <= lbrk_pkg::TX_BITS;
                    end
                end
                lbrk_pkg::TX_BITS: begin
                    if (bit_end) begin
                        tsh_q <= {1'b0, tsh_q[7:1]};
                        tbit_q <= tbit_q + 4'h1;
                        if (tbit_q == nbits - 4'h1) begin
                            tx_st_q <= lbrk_pkg::TX_STOP;
                        end
                    end
                end
                lbrk_pkg::TX_STOP: begin
                    if (bit_end) begin
                        tx_st_q <= lbrk_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Line level follows the sequencer one clock later; idle is high.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_line_q <= 1'b1;
        end else begin
            tx_line_q <= (tx_st_q == lbrk_pkg::TX_START) ? 1'b0 :
                         (tx_st_q == lbrk_pkg::TX_BITS) ? tsh_q[0] : 1'b1;
        end
    end

    // Receive pin synchroniser; edges are judged on the second stage only.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_s1_q <= receive_line;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s2_q;
        end
    end

    // Receive sequencer. A break looks like a zero byte with a low stop
    // bit; the receiver then needs a falling edge, so it waits out the
    // long low level before hunting for the next start bit.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_st_q <= lbrk_pkg::RX_IDLE;
            rcnt_q <= 4'h0;
            rbit_q <= 4'h0;
            rsh_q <= 8'h00;
        end else begin
            if (tick) begin
                rcnt_q <= rcnt_q + 4'h1;
            end
            unique case (rx_st_q)
                lbrk_pkg::RX_IDLE: begin
                    if (ctrl_q.wake) begin
                        rx_st_q <= lbrk_pkg::RX_WAKE_LOW;
                    end else if (ctrl_q.rxen && rx_fall) begin
                        rcnt_q <= 4'h0;
                        rx_st_q <= lbrk_pkg::RX_START;
                    end
                end
                lbrk_pkg::RX_START: begin
                    if (tick && rcnt_q == lbrk_pkg::OVS_MID) begin
                        rcnt_q <= 4'h0;
                        rbit_q <= 4'h0;
                        rx_st_q <= rx_s2_q ? lbrk_pkg::RX_IDLE
                                           : lbrk_pkg::RX_DATA;
                    end
                end
                lbrk_pkg::RX_DATA: begin
                    if (r_end) begin
                        rsh_q <= {rx_s2_q, rsh_q[7:1]};
                        rbit_q <= rbit_q + 4'h1;
                        if (rbit_q == lbrk_pkg::DATA_BITS - 4'h1) begin
                            rx_st_q <= lbrk_pkg::RX_STOP;
                        end
                    end
                end
                lbrk_pkg::RX_STOP: begin
                    if (r_end) begin
                        rx_st_q <= lbrk_pkg::RX_IDLE;
                    end
                end
                lbrk_pkg::RX_WAKE_LOW: begin
                    if (rx_fall) begin
                        rx_st_q <= lbrk_pkg::RX_WAKE_HIGH;
                    end
                end
                lbrk_pkg::RX_WAKE_HIGH: begin
                    if (rx_rise) begin
                        rx_st_q <= lbrk_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= lbrk_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Outputs straight from flip-flops.
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign transmit_line = tx_line_q;
    assign irq = irq_q;

endmodule

// ---- tb/lbrk_serial_asserts.sv ----
// Port-level checks for the break-capable serial port.
`timescale 1ns/1ps
module lbrk_serial_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Serial lines and interrupt
    input wire logic receive_line,
    input wire logic transmit_line,
    input wire logic irq
);
    logic [31:0] bit_q;
    logic [31:0] low_q;
    logic [31:0] high_q;
    // Committed writes that change the divisor or clear the mask.
    wire logic wr_go = avs_write && !avs_waitrequest;
    wire logic baud_wr = wr_go && avs_address == lbrk_pkg::OFS_BAUD
        && avs_byteenable[1:0] == 2'h3;
    wire logic mask_off = wr_go && avs_address == lbrk_pkg::OFS_IMASK
        && avs_byteenable[0] && avs_writedata[3:0] == 4'h0;

    // Shadow bit time and run lengths of the transmit line.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_q <= {12'h0, lbrk_pkg::BAUD_RESET, 4'h0} + 32'h10;
            low_q <= 32'h0;
            high_q <= 32'h0;
        end else begin
            if (baud_wr) begin
                bit_q <= {12'h0, avs_writedata[15:0], 4'h0} + 32'h10;
            end
            low_q <= transmit_line ? 32'h0 : low_q + 32'h1;
            high_q <= transmit_line ? high_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Reset must leave the pins quiet whatever happened before it.
    a_reset_quiet_pins:
    assert property (disable iff (1'b0) rst |=> avs_waitrequest
        && transmit_line && !irq && avs_readdata == 32'h0)
    else $error("pins not quiet after reset");
    a_one_wait_cycle:
    assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
    a_accept_single_cycle:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
    a_no_request_no_accept:
    assert property (!avs_read && !avs_write && avs_waitrequest
        |=> avs_waitrequest)
    else $error("accept without a request");
    a_unmapped_read_zero:
    assert property (avs_read && !avs_waitrequest
        && avs_address > lbrk_pkg::OFS_IMASK |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
    a_low_run_max:
    assert property (low_q <= bit_q * 32'hd)
    else $error("transmit line low longer than a break");
    a_low_whole_bits:
    assert property ($rose(transmit_line) |-> low_q % bit_q == 32'h0)
    else $error("low run not a whole number of bits");
    a_stop_before_start:
    assert property ($fell(transmit_line) |-> high_q >= bit_q)
    else $error("start bit without a full stop bit before it");
    a_masked_irq_low:
    assert property (mask_off |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
endmodule

bind lbrk_serial lbrk_serial_asserts lbrk_serial_asserts_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .receive_line(receive_line),
    .transmit_line(transmit_line),
    .irq(irq)
);

// ---- tb/lbrk_lin_node.sv ----
// Behavioural far-side bus node driving the device's receive line.
`timescale 1ns/1ps
module lbrk_lin_node #(
    parameter int BIT_CLKS = 16
) (
    // Clock
    input wire logic ref_clk,
    // Serial line toward the device
    output logic line
);
    // The bus idles recessive high between frames.
    initial line = 1'b1;

    // Start, bits LSB first, stop; a break holds twelve zero bits.
    task automatic send(input logic [7:0] d, input logic brk);
        int n;
        n = brk ? 12 : 8;
        @(posedge ref_clk);
        line <= 1'b0;
        repeat (BIT_CLKS) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            line <= brk ? 1'b0 : d[i % 8];
            repeat (BIT_CLKS) @(posedge ref_clk);
        end
        line <= 1'b1;
        repeat (BIT_CLKS) @(posedge ref_clk);
    endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the break-capable serial port.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    err_total++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_line;
    logic transmit_line;
    logic irq;
    logic [31:0] rd;
    logic [7:0] txd;
    int lows;
    int err_total = 0;
    int tests_run = 0;

    // A 100 ns clock.
    always #50 ref_clk = ~ref_clk;

    lbrk_serial lbrk_serial_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .receive_line(rx_line),
        .transmit_line(transmit_line),
        .irq(irq)
    );

    // Divisor 0 gives sixteen clocks a bit.
    lbrk_lin_node #(.BIT_CLKS(16)) lbrk_lin_node_inst (
        .ref_clk(ref_clk),
        .line(rx_line)
    );

    // Holds the request until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic chk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // Polls a status bit; gives up after a bounded number of reads.
    task automatic wait_stat(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, lbrk_pkg::OFS_STAT, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 400);
        `CHK(rd[b], 1'b1)
    endtask

    // Counts clocks for which the transmit line keeps one level.
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (transmit_line === lvl) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic summarize;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run needs under two thousand clocks.
    initial begin
        repeat (30000) @(posedge ref_clk);
        err_total++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        chk(lbrk_pkg::OFS_CTRL, 32'h0);
        chk(lbrk_pkg::OFS_BAUD, 32'h4);
        chk(lbrk_pkg::OFS_IMASK, 32'h0);
        chk(lbrk_pkg::OFS_STAT, 32'h3);
        chk(5'h1c, 32'h0);
        wr(lbrk_pkg::OFS_BAUD, 32'h0);
        wr(lbrk_pkg::OFS_IMASK, 32'hf);
        wr(lbrk_pkg::OFS_CTRL, 32'h13);
        // Watch the line while software queues the sync byte.
        fork
            begin
                run_len(1'b1, lows);
                run_len(1'b0, lows);
                `CHK(lows, 208)
                // Stop bit plus the one idle clock in which the shifter
                // takes the queued byte.
                run_len(1'b1, lows);
                `CHK(lows, 17)
                repeat (8) @(posedge ref_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (16) @(posedge ref_clk);
                    txd[i] = transmit_line;
                end
                `CHK(txd, 8'h55)
            end
            begin
                wr(lbrk_pkg::OFS_TXD, 32'ha5);
                wait_stat(1);
                chk(lbrk_pkg::OFS_STAT, 32'h2);
                wr(lbrk_pkg::OFS_TXD, 32'h55);
                chk(lbrk_pkg::OFS_CTRL, 32'h13);
            end
        join
        repeat (40) @(posedge ref_clk);
        chk(lbrk_pkg::OFS_CTRL, 32'h11);
        chk(lbrk_pkg::OFS_STAT, 32'h3);
        `CHK(irq, 1'b1)
        chk(lbrk_pkg::OFS_ISTAT, 32'h6);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        // Break from the far node, then an ordinary byte.
        lbrk_lin_node_inst.send(8'h00, 1'b1);
        wait_stat(2);
        chk(lbrk_pkg::OFS_STAT, 32'hf);
        chk(lbrk_pkg::OFS_ISTAT, 32'h9);
        chk(lbrk_pkg::OFS_RXD, 32'h0);
        // Software turns on auto-baud after the break; the bit is stored.
        wr(lbrk_pkg::OFS_CTRL, 32'h19);
        chk(lbrk_pkg::OFS_CTRL, 32'h19);
        lbrk_lin_node_inst.send(8'h3c, 1'b0);
        wait_stat(2);
        chk(lbrk_pkg::OFS_RXD, 32'h3c);
        chk(lbrk_pkg::OFS_STAT, 32'h3);
        chk(lbrk_pkg::OFS_ISTAT, 32'h1);
        // Wake on break, then the following byte.
        wr(lbrk_pkg::OFS_CTRL, 32'h15);
        lbrk_lin_node_inst.send(8'h00, 1'b1);
        wait_stat(2);
        chk(lbrk_pkg::OFS_ISTAT, 32'h1);
        chk(lbrk_pkg::OFS_RXD, 32'h0);
        chk(lbrk_pkg::OFS_CTRL, 32'h11);
        lbrk_lin_node_inst.send(8'h55, 1'b0);
        wait_stat(2);
        chk(lbrk_pkg::OFS_RXD, 32'h55);
        chk(lbrk_pkg::OFS_ISTAT, 32'h1);
        // A masked event holds the interrupt low until unmasked.
        wr(lbrk_pkg::OFS_IMASK, 32'h0);
        lbrk_lin_node_inst.send(8'h81, 1'b0);
        wait_stat(2);
        `CHK(irq, 1'b0)
        wr(lbrk_pkg::OFS_IMASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        chk(lbrk_pkg::OFS_ISTAT, 32'h1);
        chk(lbrk_pkg::OFS_RXD, 32'h81);
        `CHK(irq, 1'b0)
        // With transmit disabled a data write is refused.
        wr(lbrk_pkg::OFS_CTRL, 32'h0);
        wr(lbrk_pkg::OFS_TXD, 32'h12);
        // An accepted write would fill the holding register and start the
        // idle shifter, so both empty flags must still read set.
        chk(lbrk_pkg::OFS_STAT, 32'h3);
        repeat (40) @(posedge ref_clk);
        `CHK(transmit_line, 1'b1)
        summarize();
    end
endmodule
